// [common/pbl_cfg.svh]
// Purpose: Constants of the self-test and loopback block
// Assumes: 16-bit management registers, byte-wide datapath
// Notes: Included by the package, pbl_top and the testbench
`ifndef PBL_CFG_SVH
`define PBL_CFG_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define PBL_ADDR_CTRL 5'h16
`define PBL_ADDR_ERR 5'h1B
`define PBL_ADDR_LEN 5'h1C

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define PBL_CTRL_NEAR_LO 0
`define PBL_CTRL_NEAR_HI 3
`define PBL_CTRL_REV 4
`define PBL_CTRL_BUSY 8
`define PBL_CTRL_LOST 9
`define PBL_CTRL_LOCK 10
`define PBL_CTRL_SIZE 12
`define PBL_CTRL_SINGLE_PKT 13
`define PBL_CTRL_MODE 14
`define PBL_CTRL_RUN 15
`define PBL_CTRL_RW_MASK 16'hD01F

// ----------------------------------------
// Length register fields and reset values
// ----------------------------------------
`define PBL_LEN_LO 0
`define PBL_LEN_HI 10
`define PBL_GAP_LO 11
`define PBL_GAP_HI 15
`define PBL_CTRL_RST 16'h0000
`define PBL_LEN_RST 16'h65EE

// ----------------------------------------
// Packet generator and checker constants
// ----------------------------------------
`define PBL_SHORT_PKT 11'd64
`define PBL_LONG_PKT 11'd1518
`define PBL_MIN_LEN 11'd1
`define PBL_CONST_BYTE 8'h55
`define PBL_PRBS_SEED 15'h7FFF
`define PBL_ERR_MAX 16'hFFFF

`endif

// [common/pbl_pkg.sv]
// Purpose: Types and the shared sequence step of the self-test block
// Assumes: pbl_cfg.svh holds all numeric constants
// Notes: The step advances the 15-bit sequence by one byte
`include "pbl_cfg.svh"

package pbl_pkg;

  typedef enum logic [1:0] {
    PBL_GEN_IDLE = 2'b00,
    PBL_GEN_PKT = 2'b01,
    PBL_GEN_GAP = 2'b10
  } pbl_gen_e;

  // ----------------------------------------
  // x^15 + x^14 + 1, eight steps per byte
  // ----------------------------------------
  function automatic logic [14:0] pbl_prbs_step(input logic [14:0] s);
    logic [14:0] t;
    t = s;
    for (int i = 0; i < 8; i++) begin
      t = {t[13:0], t[14] ^ t[13]};
    end
    return t;
  endfunction

endpackage

// [tb/pbl_line_model.sv]
// Purpose: Line side stand-in, a link partner source or a return fixture
// Assumes: One byte per cycle on the line in each direction
// Notes: Idle receive data shows the inverse of the last byte
module pbl_line_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic line_tx_valid,
  input wire logic [7:0] line_tx_data,
  output logic line_tx_ready,
  output logic line_rx_valid,
  output logic [7:0] line_rx_data,
  input wire logic loop_en,
  input wire logic [1:0] stall,
  input wire logic bad,
  input wire logic src_valid,
  input wire logic [7:0] src_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ret_valid;
  logic [7:0] ret_data;
  logic [7:0] last;

  // Stall 0 never, 1 a random quarter, 2 always
  always @(posedge clk) begin
    if (rst) begin
      line_tx_ready <= 1'b0;
      ret_valid <= 1'b0;
      ret_data <= 8'h00;
      last <= 8'h00;
    end else begin
      line_tx_ready <= (stall == 2'd0) || (stall == 2'd1 && $urandom_range(3) != 0);
      ret_valid <= loop_en && line_tx_valid && line_tx_ready;
      ret_data <= bad ? ~line_tx_data : line_tx_data;
      if (line_rx_valid)
        last <= line_rx_data;
    end
  end

  assign line_rx_valid = loop_en ? ret_valid : src_valid;
  // Stale value would hide a sampling slip, so invert it
  assign line_rx_data = !line_rx_valid ? ~last : (loop_en ? ret_data : src_data);
endmodule

// [tb/prbs_bist_far_loopback_tb.sv]
// Purpose: Self-checking bench of reverse loop and packet self-test
// Assumes: Short lock and loss counts; line model as fixture or source
// Notes: Expected bytes are queued by the bench model
`include "pbl_cfg.svh"
module prbs_bist_far_loopback_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0;
  logic rst = 1;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic [4:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0;
  logic [15:0] reg_rdata;
  logic speed_100 = 0;
  logic rmii_mode = 0;
  logic [3:0] near_loop_sel;
  logic mac_tx_valid = 0;
  logic [7:0] mac_tx_data = 0;
  logic mac_tx_ready, mac_rx_valid, line_rx_valid, line_tx_valid, line_tx_ready;
  logic [7:0] mac_rx_data, line_rx_data, line_tx_data;
  logic loop_en = 0;
  logic bad = 0;
  logic src_valid = 0;
  logic [7:0] src_data = 0;
  logic [1:0] stall = 0;
  logic mac_on = 0;
  logic mac_rec = 0;
  logic [14:0] lfsr;
  logic [7:0] txq[$], rxq[$], exp_tx[$], exp_rx[$];
  int error_cnt = 0;
  int n_compared = 0;

  always #5 clk = ~clk;

  pbl_top #(.LOCK_RUN(4), .LOSS_RUN(2), .FIFO_DEPTH(8)) dut (
    .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .speed_100(speed_100), .rmii_mode(rmii_mode),
    .near_loop_sel(near_loop_sel), .mac_tx_valid(mac_tx_valid), .mac_tx_data(mac_tx_data),
    .mac_tx_ready(mac_tx_ready), .mac_rx_valid(mac_rx_valid), .mac_rx_data(mac_rx_data),
    .line_rx_valid(line_rx_valid), .line_rx_data(line_rx_data), .line_tx_valid(line_tx_valid),
    .line_tx_data(line_tx_data), .line_tx_ready(line_tx_ready));

  pbl_line_model line (
    .clk(clk), .rst(rst), .line_tx_valid(line_tx_valid), .line_tx_data(line_tx_data),
    .line_tx_ready(line_tx_ready), .line_rx_valid(line_rx_valid), .line_rx_data(line_rx_data),
    .loop_en(loop_en), .stall(stall), .bad(bad), .src_valid(src_valid), .src_data(src_data));

  // ----------------------------------------
  // MAC traffic and monitors
  // ----------------------------------------
  always @(negedge clk) begin
    mac_tx_valid <= mac_on & 1'($urandom_range(1));
    mac_tx_data <= 8'($urandom);
  end

  always @(posedge clk) begin
    if (line_tx_valid === 1'b1 && line_tx_ready === 1'b1)
      txq.push_back(line_tx_data);
    if (mac_rx_valid === 1'b1)
      rxq.push_back(mac_rx_data);
    if (mac_rec && mac_tx_valid && mac_tx_ready === 1'b1)
      exp_tx.push_back(mac_tx_data);
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("compared=%0d errors=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 0;
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
    @(negedge clk);
    reg_rd = 1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 0;
    check(reg_rdata & m, e);
  endtask

  task automatic send(input int n, input int spacing, input int keep);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      src_valid = 1;
      src_data = 8'($urandom);
      exp_rx.push_back(src_data);
      if (i < keep)
        exp_tx.push_back(src_data);
      repeat (spacing) begin
        @(negedge clk);
        src_valid = 0;
      end
    end
    @(negedge clk);
    src_valid = 0;
  endtask

  task automatic wait_tx(input int n);
    int k;
    k = 0;
    while (txq.size() < n && k < 4000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 4000)
      check(16'(txq.size()), 16'(n));
  endtask

  task automatic corrupt_n(input int n);
    int k;
    k = 0;
    @(negedge clk);
    bad = 1;
    while (k < n) begin
      @(posedge clk);
      if (line_tx_valid === 1'b1 && line_tx_ready === 1'b1)
        k++;
    end
    @(negedge clk);
    bad = 0;
  endtask

  task automatic cmp_q(input bit exact, input bit with_rx);
    if (!exact)
      while (txq.size() > exp_tx.size()) void'(txq.pop_back());
    check(16'(txq.size()), 16'(exp_tx.size()));
    foreach (exp_tx[i]) if (i < txq.size()) check({8'h00, txq[i]}, {8'h00, exp_tx[i]});
    if (with_rx) begin
      check(16'(rxq.size()), 16'(exp_rx.size()));
      foreach (exp_rx[i]) if (i < rxq.size()) check({8'h00, rxq[i]}, {8'h00, exp_rx[i]});
    end
    txq = {};
    rxq = {};
    exp_tx = {};
    exp_rx = {};
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    #200000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'hF93D));
    repeat (10) @(negedge clk);
    rst = 0;
    rd_chk(`PBL_ADDR_CTRL, 16'hFFFF, 16'h0000);
    rd_chk(`PBL_ADDR_LEN, 16'hFFFF, 16'h65EE);
    wr(`PBL_ADDR_ERR, 16'h1234);
    rd_chk(`PBL_ADDR_ERR, 16'hFFFF, 16'h0000);
    rd_chk(5'h00, 16'hFFFF, 16'h0000);
    wr(`PBL_ADDR_CTRL, 16'h400F);
    rd_chk(`PBL_ADDR_CTRL, 16'hFFFF, 16'h400F);
    check({12'h000, near_loop_sel}, 16'h000F);
    for (int m = 0; m < 2; m++) begin
      rmii_mode = (m == 0);
      speed_100 = (m == 1);
      wr(`PBL_ADDR_CTRL, 16'h0010);
      mac_on = 1;
      send(12, 1, 12);
      check({15'h0, mac_tx_ready}, 16'h0001);
      idle(20);
      cmp_q(1, 1);
    end
    @(negedge clk);
    mac_on = 0;
    stall = 2;
    idle(3);
    send(10, 0, 8);
    check({15'h0, line_tx_valid}, 16'h0001);
    stall = 0;
    idle(20);
    check({15'h0, line_tx_valid}, 16'h0000);
    cmp_q(1, 1);
    // Loop bit without effect, then loop bit cleared
    for (int m = 0; m < 2; m++) begin
      rmii_mode = (m == 0);
      speed_100 = 1;
      wr(`PBL_ADDR_CTRL, (m == 0) ? 16'h0010 : 16'h0000);
      stall = 1;
      mac_rec = 1;
      mac_on = 1;
      send(12, 1, 0);
      @(posedge clk);
      mac_on = 0;
      idle(2);
      mac_rec = 0;
      stall = 0;
      idle(20);
      cmp_q(1, 1);
    end
    // Speed is forced, no autonegotiation to turn off
    rmii_mode = 0;
    loop_en = 1;
    stall = 1;
    wr(`PBL_ADDR_LEN, 16'hF805);
    rd_chk(`PBL_ADDR_LEN, 16'hFFFF, 16'hF805);
    lfsr = `PBL_PRBS_SEED;
    for (int i = 0; i < 30; i++) begin
      repeat (8) lfsr = {lfsr[13:0], lfsr[14] ^ lfsr[13]};
      exp_tx.push_back(lfsr[7:0]);
    end
    wr(`PBL_ADDR_CTRL, 16'h8000);
    wait_tx(5);
    idle(10);
    check(16'(txq.size()), 16'd5);
    wait_tx(30);
    cmp_q(0, 0);
    rd_chk(`PBL_ADDR_CTRL, 16'h0600, 16'h0400);
    rd_chk(`PBL_ADDR_ERR, 16'hFFFF, 16'h0000);
    corrupt_n(1);
    idle(4);
    rd_chk(`PBL_ADDR_ERR, 16'hFFFF, 16'h0001);
    rd_chk(`PBL_ADDR_CTRL, 16'h0600, 16'h0400);
    corrupt_n(6);
    idle(2);
    rd_chk(`PBL_ADDR_CTRL, 16'h0200, 16'h0200);
    wr(`PBL_ADDR_CTRL, 16'h0000);
    wr(`PBL_ADDR_CTRL, 16'h8000);
    rd_chk(`PBL_ADDR_ERR, 16'hFFFF, 16'h0000);
    rd_chk(`PBL_ADDR_CTRL, 16'h0200, 16'h0000);
    wr(`PBL_ADDR_CTRL, 16'h0000);
    idle(80);
    cmp_q(0, 0);
    for (int s = 0; s < 2; s++) begin
      wr(`PBL_ADDR_CTRL, (s == 1) ? 16'h3000 : 16'h2000);
      rd_chk(`PBL_ADDR_CTRL, 16'h2100, 16'h0100);
      repeat ((s == 1) ? `PBL_LONG_PKT : `PBL_SHORT_PKT) exp_tx.push_back(`PBL_CONST_BYTE);
      wait_tx(exp_tx.size());
      idle(60);
      cmp_q(1, 0);
      rd_chk(`PBL_ADDR_CTRL, 16'h0100, 16'h0000);
    end
    print_verdict();
  end
endmodule

// [verilog/pbl_fifo.sv]
// Purpose: Transmit buffer between source select and the line
// Assumes: Single clock, show-ahead output
// Notes: in_ready falls when full; out_valid falls when empty
module pbl_fifo
  import pbl_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Read data stays where the pointer points until popped
  always_ff @(posedge clk) begin
    if (rst) begin
      out_data <= '0;
    end else begin
      out_data <= mem[next_rd_ptr];
      if (push && (next_rd_ptr == wr_ptr)) begin
        out_data <= in_data;
      end
    end
  end
endmodule

// [verilog/pbl_top.sv]
// Purpose: Reverse loopback and packet self-test of the PHY datapath
// Assumes: Byte-wide datapath on clk; registers reached by management port
// Notes: Line receive bytes come from the receive chain on clk
`include "pbl_cfg.svh"
module pbl_top
  import pbl_pkg::*;
#(
  parameter int LOCK_RUN = 16,
  parameter int LOSS_RUN = 8,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic speed_100,
  input wire logic rmii_mode,
  output logic [3:0] near_loop_sel,
  input wire logic mac_tx_valid,
  input wire logic [7:0] mac_tx_data,
  output logic mac_tx_ready,
  output logic mac_rx_valid,
  output logic [7:0] mac_rx_data,
  input wire logic line_rx_valid,
  input wire logic [7:0] line_rx_data,
  output logic line_tx_valid,
  output logic [7:0] line_tx_data,
  input wire logic line_tx_ready
);
  // ----------------------------------------
  // Management registers
  // ----------------------------------------
  logic [15:0] ctrl, next_ctrl, len_reg, next_len_reg;
  logic single_trig, next_single_trig, run_start;
  logic gen_busy, chk_locked, chk_lost;
  logic [15:0] err_cnt;

  assign run_start = next_ctrl[`PBL_CTRL_RUN] && !ctrl[`PBL_CTRL_RUN];

  always_comb begin
    next_ctrl = ctrl;
    next_len_reg = len_reg;
    next_single_trig = 1'b0;
    if (reg_wr && (reg_addr == `PBL_ADDR_CTRL)) begin
      next_ctrl = reg_wdata & `PBL_CTRL_RW_MASK;
      next_single_trig = reg_wdata[`PBL_CTRL_SINGLE_PKT];
    end
    if (reg_wr && (reg_addr == `PBL_ADDR_LEN)) begin
      next_len_reg = reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= `PBL_CTRL_RST;
      len_reg <= `PBL_LEN_RST;
      single_trig <= 1'b0;
      reg_rdata <= '0;
    end else begin
      ctrl <= next_ctrl;
      len_reg <= next_len_reg;
      single_trig <= next_single_trig;
      reg_rdata <= '0;
      if (reg_rd) begin
        unique case (reg_addr)
          `PBL_ADDR_CTRL: begin
            reg_rdata <= ctrl;
            reg_rdata[`PBL_CTRL_BUSY] <= gen_busy;
            reg_rdata[`PBL_CTRL_LOST] <= chk_lost;
            reg_rdata[`PBL_CTRL_LOCK] <= chk_locked;
          end
          `PBL_ADDR_ERR: reg_rdata <= err_cnt;
          `PBL_ADDR_LEN: reg_rdata <= len_reg;
          default: reg_rdata <= '0;
        endcase
      end
    end
  end

  assign near_loop_sel = ctrl[`PBL_CTRL_NEAR_HI:`PBL_CTRL_NEAR_LO];
  // ----------------------------------------
  // Transmit source select and buffer
  // ----------------------------------------
  logic rev_act, bist_sel, fifo_in_valid, fifo_in_ready;
  logic [7:0] fifo_in_data, gen_data;
  pbl_gen_e gen_state;

  // 2-bit interface cannot turn around at 100 Mb/s
  assign rev_act = ctrl[`PBL_CTRL_REV] && !(rmii_mode && speed_100);
  assign bist_sel = !rev_act && (ctrl[`PBL_CTRL_RUN] || gen_busy);

  always_comb begin
    if (rev_act) begin
      fifo_in_valid = line_rx_valid;
      fifo_in_data = line_rx_data;
    end else if (bist_sel) begin
      fifo_in_valid = (gen_state == PBL_GEN_PKT);
      fifo_in_data = gen_data;
    end else begin
      fifo_in_valid = mac_tx_valid;
      fifo_in_data = mac_tx_data;
    end
  end

  // MAC bytes are swallowed, not stalled, while another source owns the line
  assign mac_tx_ready = (rev_act || bist_sel) ? 1'b1 : fifo_in_ready;

  pbl_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(fifo_in_valid),
    .in_data(fifo_in_data),
    .in_ready(fifo_in_ready),
    .out_valid(line_tx_valid),
    .out_data(line_tx_data),
    .out_ready(line_tx_ready)
  );

  // Receive always reaches the MAC, also in reverse loopback
  always_ff @(posedge clk) begin
    if (rst) begin
      mac_rx_valid <= 1'b0;
      mac_rx_data <= '0;
    end else begin
      mac_rx_valid <= line_rx_valid;
      mac_rx_data <= line_rx_data;
    end
  end

  // ----------------------------------------
  // Packet generator
  // ----------------------------------------
  pbl_gen_e next_gen_state;
  logic [14:0] gen_lfsr, next_gen_lfsr, gen_step;
  logic [10:0] gen_cnt, next_gen_cnt, gen_len, next_gen_len, prog_len;
  logic gen_single, next_gen_single, gen_fire;

  assign gen_step = pbl_prbs_step(gen_lfsr);
  assign gen_fire = bist_sel && (gen_state == PBL_GEN_PKT) && fifo_in_ready;
  assign gen_busy = (gen_state != PBL_GEN_IDLE);
  assign gen_data = gen_single ? `PBL_CONST_BYTE : gen_step[7:0];
  assign prog_len = (len_reg[`PBL_LEN_HI:`PBL_LEN_LO] < `PBL_MIN_LEN) ? `PBL_MIN_LEN
                    : len_reg[`PBL_LEN_HI:`PBL_LEN_LO];

  always_comb begin
    next_gen_state = gen_state;
    next_gen_lfsr = gen_lfsr;
    next_gen_cnt = gen_cnt;
    next_gen_len = gen_len;
    next_gen_single = gen_single;
    unique case (gen_state)
      PBL_GEN_IDLE: begin
        next_gen_cnt = '0;
        if (single_trig && !rev_act) begin
          next_gen_state = PBL_GEN_PKT;
          next_gen_single = 1'b1;
          next_gen_len = ctrl[`PBL_CTRL_SIZE] ? `PBL_LONG_PKT : `PBL_SHORT_PKT;
        end else if (ctrl[`PBL_CTRL_RUN] && !rev_act) begin
          next_gen_state = PBL_GEN_PKT;
          next_gen_single = 1'b0;
          next_gen_len = prog_len;
        end
      end
      PBL_GEN_PKT: begin
        if (gen_fire) begin
          next_gen_cnt = gen_cnt + 11'd1;
          if (!gen_single) begin
            next_gen_lfsr = gen_step;
          end
          if (gen_cnt == gen_len - 11'd1) begin
            next_gen_state = PBL_GEN_GAP;
            next_gen_cnt = '0;
          end
        end
      end
      PBL_GEN_GAP: begin
        next_gen_cnt = gen_cnt + 11'd1;
        if (gen_cnt >= {6'd0, len_reg[`PBL_GAP_HI:`PBL_GAP_LO]}) begin
          next_gen_cnt = '0;
          next_gen_len = prog_len;
          next_gen_state = (gen_single || !ctrl[`PBL_CTRL_RUN]) ? PBL_GEN_IDLE : PBL_GEN_PKT;
          next_gen_single = 1'b0;
        end
      end
      default: next_gen_state = PBL_GEN_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      gen_state <= PBL_GEN_IDLE;
      gen_lfsr <= `PBL_PRBS_SEED;
      gen_cnt <= '0;
      gen_len <= `PBL_MIN_LEN;
      gen_single <= 1'b0;
    end else begin
      gen_state <= next_gen_state;
      gen_lfsr <= next_gen_lfsr;
      gen_cnt <= next_gen_cnt;
      gen_len <= next_gen_len;
      gen_single <= next_gen_single;
    end
  end

  // ----------------------------------------
  // Checker
  // ----------------------------------------
  logic [14:0] chk_lfsr, next_chk_lfsr, chk_step;
  logic [7:0] match_cnt, next_match_cnt, miss_cnt, next_miss_cnt;
  logic next_chk_locked, next_chk_lost, chk_hit, chk_on;
  logic [15:0] next_err_cnt;

  assign chk_step = pbl_prbs_step(chk_lfsr);
  assign chk_on = ctrl[`PBL_CTRL_RUN] && line_rx_valid;
  assign chk_hit = (line_rx_data == chk_step[7:0]);

  always_comb begin
    next_chk_lfsr = chk_lfsr;
    next_match_cnt = match_cnt;
    next_miss_cnt = miss_cnt;
    next_chk_locked = chk_locked;
    next_chk_lost = chk_lost;
    next_err_cnt = err_cnt;
    if (run_start) begin
      next_match_cnt = '0;
      next_miss_cnt = '0;
      next_chk_locked = 1'b0;
      next_chk_lost = 1'b0;
      next_err_cnt = '0;
    end else if (chk_on) begin
      // Unlocked: the last two bytes reseed the local sequence
      next_chk_lfsr = chk_locked ? chk_step : {chk_lfsr[6:0], line_rx_data};
      if (chk_hit) begin
        next_miss_cnt = '0;
        if (!chk_locked) begin
          next_match_cnt = match_cnt + 8'd1;
          if (match_cnt == 8'(LOCK_RUN - 1)) begin
            next_chk_locked = 1'b1;
          end
        end
      end else begin
        next_match_cnt = '0;
        if (chk_locked) begin
          next_miss_cnt = miss_cnt + 8'd1;
          if (err_cnt != `PBL_ERR_MAX) begin
            next_err_cnt = err_cnt + 16'd1;
          end else if (!ctrl[`PBL_CTRL_MODE]) begin
            next_err_cnt = '0;
          end
          if (miss_cnt == 8'(LOSS_RUN - 1)) begin
            next_chk_locked = 1'b0;
            next_chk_lost = 1'b1;
            next_miss_cnt = '0;
          end
        end
      end
    end
    if (run_start && chk_on && chk_locked && !chk_hit && (miss_cnt == 8'(LOSS_RUN - 1))) begin
      next_chk_lost = 1'b1; // Set beats the start clear
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      chk_lfsr <= `PBL_PRBS_SEED;
      match_cnt <= '0;
      miss_cnt <= '0;
      chk_locked <= 1'b0;
      chk_lost <= 1'b0;
      err_cnt <= '0;
    end else begin
      chk_lfsr <= next_chk_lfsr;
      match_cnt <= next_match_cnt;
      miss_cnt <= next_miss_cnt;
      chk_locked <= next_chk_locked;
      chk_lost <= next_chk_lost;
      err_cnt <= next_err_cnt;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_trig_write;
    reg_wr && (reg_addr == `PBL_ADDR_CTRL) && reg_wdata[`PBL_CTRL_SINGLE_PKT] && !rev_act;
  endsequence
  sequence s_idle_gen;
    (gen_state == PBL_GEN_IDLE) && !rev_act;
  endsequence

  AST_REV_TURNS: assert property (rev_act && line_rx_valid |->
    fifo_in_valid && (fifo_in_data == line_rx_data)) else $error("reverse loop lost a byte");
  AST_RX_TO_MAC: assert property (line_rx_valid |=>
    mac_rx_valid && (mac_rx_data == $past(line_rx_data))) else $error("receive not shown to MAC");
  AST_RMII_10_ONLY: assert property (rmii_mode && speed_100 |-> !rev_act)
    else $error("reverse loop at 100 Mb/s on 2-bit interface");
  AST_PRBS_ADVANCE: assert property (gen_fire && !gen_single |=>
    gen_lfsr == pbl_prbs_step($past(gen_lfsr))) else $error("sequence did not advance");
  AST_ERR_WRAP: assert property (!run_start && chk_on && chk_locked && !chk_hit &&
    !ctrl[`PBL_CTRL_MODE] && (err_cnt == `PBL_ERR_MAX) |=> err_cnt == 16'h0000)
    else $error("error count did not wrap");
  AST_ERR_HOLD: assert property (!run_start && ctrl[`PBL_CTRL_MODE] &&
    (err_cnt == `PBL_ERR_MAX) |=> err_cnt == `PBL_ERR_MAX) else $error("error count left maximum");
  AST_SINGLE_START: assert property (s_trig_write ##1 s_idle_gen |=>
    gen_busy && gen_single) else $error("single packet not started");
  AST_CONST_DATA: assert property (bist_sel && fifo_in_valid && gen_single |->
    fifo_in_data == `PBL_CONST_BYTE) else $error("single packet payload not constant");
  AST_START_CLEARS: assert property (run_start |=>
    (err_cnt == 16'h0000) && !chk_locked) else $error("start did not clear status");
  AST_LOCK_RUN: assert property ($rose(chk_locked) |->
    $past(match_cnt) == 8'(LOCK_RUN - 1)) else $error("lock without match run");
endmodule
